// File: bench/smt_top_chk.sv
// Port-level checker for the split-mode dual 8-bit timer.
// Assumes the APB master keeps paddr word aligned on mapped registers.
`timescale 1ns/1ps

module smt_top_chk (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        debug_halt,
    input wire logic        irq,
    input wire logic [2:0]  low_match,
    input wire logic [2:0]  high_match
);
    // ======================================================================
    // Helpers
    logic       acc;
    logic       rd_ok;
    logic [5:0] idx;
    assign acc   = psel && penable;
    assign idx   = paddr[7:2];
    assign rd_ok = acc && !pwrite && !pslverr;

    // ======================================================================
    // Properties
    a_ready_setup: assert property (@(posedge clk) disable iff (rst)
        psel && !penable |-> !pready) else $error("pready high in setup");
    a_ready_access: assert property (@(posedge clk) disable iff (rst)
        psel && !penable |=> pready) else $error("pready missing in access");
    a_upper_zero: assert property (@(posedge clk) disable iff (rst)
        acc && !pwrite |-> prdata[31:8] == 24'h000000) else $error("upper read bits set");
    a_cmd_reads_zero: assert property (@(posedge clk) disable iff (rst)
        rd_ok && (idx == 6'h04 || idx == 6'h05) |-> prdata[7:2] == 6'h00)
        else $error("command field read nonzero");
    a_align_err: assert property (@(posedge clk) disable iff (rst)
        acc && paddr[1:0] != 2'h0 |-> pslverr) else $error("misaligned access accepted");
    a_mapped_ok: assert property (@(posedge clk) disable iff (rst)
        acc && paddr[1:0] == 2'h0 && idx inside {6'h00, 6'h03, 6'h04, 6'h05, 6'h0a, 6'h0b,
        6'h0e, 6'h20, 6'h21, 6'h26, 6'h27} |-> !pslverr) else $error("mapped register refused");
    a_flag_layout: assert property (@(posedge clk) disable iff (rst)
        rd_ok && (idx == 6'h0a || idx == 6'h0b) |-> (prdata[7:0] & 8'h8c) == 8'h00)
        else $error("unused flag bits set");
    a_debug_layout: assert property (@(posedge clk) disable iff (rst)
        rd_ok && idx == 6'h0e |-> prdata[7:1] == 7'h00) else $error("debug bits set");
    a_rdata_hold: assert property (@(posedge clk) disable iff (rst)
        acc ##1 !psel |-> $stable(prdata)) else $error("read data moved after access");
    c_flag_read: cover property (@(posedge clk) disable iff (rst) rd_ok && idx == 6'h0b);
endmodule // smt_top_chk

bind smt_top smt_top_chk u_chk (
    .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .debug_halt(debug_halt), .irq(irq), .low_match(low_match), .high_match(high_match)
);

// File: bench/testbench.sv
// Self-checking bench of the split-mode dual 8-bit timer over APB.
// Assumes zero-wait APB and a div1 tick on every cycle that counting runs, except in the final div2 restart check.
`timescale 1ns/1ps
`include "smt_regs.svh"

module testbench;
    logic        clk        = 1'b0;
    logic        rst        = 1'b1;
    logic [7:0]  paddr      = 8'h00;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [31:0] pwdata     = 32'h00000000;
    logic        debug_halt = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [2:0]  low_match;
    logic [2:0]  high_match;
    logic [31:0] lfsr_q     = 32'h54b90e5a;
    logic [31:0] rd;
    logic        er;
    int          errors     = 0;
    int          n_tests    = 0;
    int          lc, hc, lt, fl;
    int          cm[3];
    logic [5:0]  ri[14] = '{6'h00, 6'h03, 6'h04, 6'h05, 6'h0a, 6'h0b, 6'h0e, 6'h20, 6'h21,
                            6'h26, 6'h27, 6'h28, 6'h29, 6'h2d};
    logic [5:0]  wi[8]  = '{6'h0a, 6'h0e, 6'h20, 6'h21, 6'h26, 6'h27, 6'h28, 6'h2b};
    logic [7:0]  wm[8]  = '{8'h73, 8'h01, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};

    always #4 clk = ~clk;

    smt_top uut (
        .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .debug_halt(debug_halt), .irq(irq),
        .low_match(low_match), .high_match(high_match)
    );

    // ======================================================================
    // Helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer, released at the rising edge that samples pready high
    task automatic apb(input logic [5:0] idx, input logic wr, input logic [7:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'h0};
        pwdata  <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
        apb(idx, 1'b0, 8'h00);
        check(rd, {24'h000000, exp});
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ======================================================================
    // Watchdog: whole sequence needs well under 10 us
    initial begin
        #100000;
        errors++;
        tally_and_finish();
    end

    // ======================================================================
    // Tests
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        foreach (ri[i]) rd_chk(ri[i], (ri[i] == 6'h26 || ri[i] == 6'h27) ? 8'hff : 8'h00);
        apb(6'h01, 1'b0, 8'h00);
        check({31'h0, er}, 32'h1);
        $display("reset values done");
        foreach (wi[i]) begin
            lfsr_q = lfsr_next(lfsr_q);
            apb(wi[i], 1'b1, lfsr_q[7:0]);
            rd_chk(wi[i], lfsr_q[7:0] & wm[i]);
        end
        $display("read write done");
        apb(`SMT_IDX_CMD_SET, 1'b1, 8'h01);
        rd_chk(`SMT_IDX_CMD_CLR, 8'h01);
        apb(6'h20, 1'b1, 8'h21);
        apb(6'h21, 1'b1, 8'h43);
        apb(6'h26, 1'b1, 8'h10);
        apb(6'h27, 1'b1, 8'h20);
        apb(`SMT_IDX_CMD_SET, 1'b1, 8'h0e);
        rd_chk(`SMT_IDX_CMD_SET, 8'h03);
        rd_chk(6'h20, 8'h21);
        apb(`SMT_IDX_CMD_CLR, 1'b1, 8'h01);
        rd_chk(`SMT_IDX_CMD_SET, 8'h02);
        apb(`SMT_IDX_CMD_SET, 1'b1, 8'h07);
        rd_chk(6'h21, 8'h43);
        apb(`SMT_IDX_CMD_SET, 1'b1, 8'h0b);
        rd_chk(6'h20, 8'h10);
        rd_chk(6'h21, 8'h20);
        apb(6'h20, 1'b1, 8'h21);
        apb(6'h00, 1'b1, 8'h01);
        apb(`SMT_IDX_CMD_SET, 1'b1, 8'h0f);
        rd_chk(6'h20, 8'h21);
        apb(6'h00, 1'b1, 8'h00);
        apb(`SMT_IDX_CMD_SET, 1'b1, 8'h0f);
        rd_chk(6'h20, 8'h00);
        rd_chk(6'h26, 8'hff);
        rd_chk(6'h28, 8'h00);
        rd_chk(`SMT_IDX_CMD_CLR, 8'h00);
        $display("commands done");
        debug_halt <= 1'b1;
        apb(6'h0e, 1'b1, 8'h00);
        apb(6'h20, 1'b1, 8'h02);
        apb(6'h21, 1'b1, 8'h01);
        apb(6'h26, 1'b1, 8'h10);
        apb(6'h28, 1'b1, 8'h01);
        apb(6'h0a, 1'b1, 8'h01);
        apb(6'h03, 1'b1, 8'h01);
        apb(6'h00, 1'b1, 8'h01);
        rd_chk(6'h20, 8'h02);
        rd_chk(6'h0b, 8'h00);
        @(posedge clk);
        debug_halt <= 1'b0;
        repeat (4) @(posedge clk);
        debug_halt <= 1'b1;
        lc = 2;
        hc = 1;
        lt = 8'h10;
        fl = 0;
        cm = '{1, 0, 0};
        repeat (4) begin
            for (int n = 0; n < 3; n++) if (lc == cm[n]) fl |= (8'h10 << n);
            if (lc == 0) begin
                lc = lt;
                fl |= 1;
            end else lc--;
            if (hc == 0) begin
                hc = 8'hff;
                fl |= 2;
            end else hc--;
        end
        rd_chk(6'h20, lc[7:0]);
        rd_chk(6'h21, hc[7:0]);
        rd_chk(6'h0b, fl[7:0]);
        check({29'h0, low_match}, 32'h0);
        check({29'h0, high_match}, 32'h0);
        check({31'h0, irq}, 32'h1);
        apb(6'h0b, 1'b1, 8'h11);
        rd_chk(6'h0b, fl[7:0] & 8'hee);
        rd_chk(6'h20, lc[7:0]);
        apb(6'h0a, 1'b1, 8'h02);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, 32'h1);
        apb(6'h0b, 1'b1, 8'h02);
        rd_chk(6'h0b, fl[7:0] & 8'hec);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        apb(6'h0a, 1'b1, 8'h20);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, 32'h1);
        apb(6'h0b, 1'b1, 8'h73);
        rd_chk(6'h0b, 8'h00);
        $display("flags done");
        apb(6'h0e, 1'b1, 8'h01);
        apb(6'h20, 1'b1, 8'h80);
        apb(6'h20, 1'b0, 8'h00);
        // One tick lands before the setup edge that captures the count
        check({24'h000000, rd[7:0]}, 32'h0000007f);
        // Divide by two after a restart: no tick at the first edge
        apb(6'h00, 1'b1, 8'h03);
        apb(`SMT_IDX_CMD_SET, 1'b1, 8'h0b);
        rd_chk(6'h20, 8'h10);
        apb(6'h0e, 1'b1, 8'h00);
        $display("debug run done");
        tally_and_finish();
    end
endmodule // testbench

// File: verilog/smt_byte_timer.sv
// One 8-bit down counter of the split timer with reload from its top value.
// Assumes tick, write and command strobes from logic on the same clock.
`timescale 1ns/1ps
`include "smt_regs.svh"

module smt_byte_timer (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       tick,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_val,
    input  wire logic       restart,
    input  wire logic       hard_clear,
    input  wire logic [7:0] top,
    output logic [7:0]      count,
    output logic            underflow
);

    smt_pkg::smt_cnt_t cnt_reg;
    smt_pkg::smt_cnt_t cnt_next;

    assign count = cnt_reg.cnt;
    // Software write wins, so a reload in the same cycle is lost and flags nothing
    assign underflow = tick && !wr_en && !restart && !hard_clear
                       && (cnt_reg.cnt == `SMT_ZERO8);

    always_comb begin
        cnt_next = cnt_reg;
        if (wr_en) begin
            cnt_next.cnt = wr_val;
        end else if (hard_clear) begin
            cnt_next.cnt = `SMT_ZERO8;
        end else if (restart) begin
            cnt_next.cnt = top;
        end else if (tick) begin
            if (cnt_reg.cnt == `SMT_ZERO8) begin
                cnt_next.cnt = top;
            end else begin
                cnt_next.cnt = cnt_reg.cnt - 8'h01;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

endmodule // smt_byte_timer

// File: verilog/smt_pkg.sv
// Types of the split-mode dual 8-bit timer.
// Assumes smt_regs.svh for all numeric constants.
package smt_pkg;

    // Command field encodings in order 0..3
    typedef enum logic [1:0] {
        smt_cmd_none,
        smt_cmd_rsvd,
        smt_cmd_restart,
        smt_cmd_reset
    } smt_cmd_t;

    typedef struct packed {
        logic [9:0] cnt;
    } smt_psc_t;

    typedef struct packed {
        logic [7:0] cnt;
    } smt_cnt_t;

    typedef struct packed {
        logic            enable;
        logic [2:0]      clksel;
        logic            split;
        logic [1:0]      target;
        logic [7:0]      inten;
        logic [7:0]      flags;
        logic            run_halt;
        logic [7:0]      low_top;
        logic [7:0]      high_top;
        logic [2:0][7:0] low_cmp;
        logic [2:0][7:0] high_cmp;
        logic [2:0]      low_match;
        logic [2:0]      high_match;
        logic            irq;
        logic [31:0]     rdata;
        logic            slverr;
    } smt_regs_t;

endpackage

// File: verilog/smt_prescaler.sv
// Shared prescaler: one-cycle tick enable at clk / 2^k as clksel selects.
// Assumes run and clear come from logic on the same clock.
`timescale 1ns/1ps
`include "smt_regs.svh"

module smt_prescaler (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       run,
    input  wire logic       clear,
    input  wire logic [2:0] sel,
    output logic            tick
);

    smt_pkg::smt_psc_t psc_reg;
    smt_pkg::smt_psc_t psc_next;

    function automatic logic [9:0] tap_mask(input logic [2:0] s);
        case (s)
            3'h0:    tap_mask = `SMT_PSC_DIV1;
            3'h1:    tap_mask = `SMT_PSC_DIV2;
            3'h2:    tap_mask = `SMT_PSC_DIV4;
            3'h3:    tap_mask = `SMT_PSC_DIV8;
            3'h4:    tap_mask = `SMT_PSC_DIV16;
            3'h5:    tap_mask = `SMT_PSC_DIV64;
            3'h6:    tap_mask = `SMT_PSC_DIV256;
            default: tap_mask = `SMT_PSC_DIV1024;
        endcase
    endfunction

    // Tick when all selected low bits are one, so divide by 1 ticks every cycle
    assign tick = run && ((psc_reg.cnt & tap_mask(sel)) == tap_mask(sel));

    always_comb begin
        psc_next = psc_reg;
        if (clear) begin
            psc_next.cnt = '0;
        end else if (run) begin
            psc_next.cnt = psc_reg.cnt + `SMT_PSC_ONE;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            psc_reg <= '0;
        end else begin
            psc_reg <= psc_next;
        end
    end

endmodule // smt_prescaler

// File: verilog/smt_regs.svh
// Register indices, field positions, reset values and prescaler taps of the split timer.
// Assumes APB byte address = register index * 4.
`ifndef SMT_REGS_SVH
`define SMT_REGS_SVH

// ==========================================================================
// Register indices
`define SMT_IDX_CTRL_A      6'h00
`define SMT_IDX_SPLIT       6'h03
`define SMT_IDX_CMD_CLR     6'h04
`define SMT_IDX_CMD_SET     6'h05
`define SMT_IDX_INT_EN      6'h0a
`define SMT_IDX_INT_FLAG    6'h0b
`define SMT_IDX_DEBUG       6'h0e
`define SMT_IDX_LOW_COUNT   6'h20
`define SMT_IDX_HIGH_COUNT  6'h21
`define SMT_IDX_LOW_TOP     6'h26
`define SMT_IDX_HIGH_TOP    6'h27
`define SMT_IDX_CMP_FIRST   6'h28
`define SMT_IDX_CMP_LAST    6'h2d

// ==========================================================================
// Field positions
`define SMT_EN_BIT          0
`define SMT_CLKSEL_HI       3
`define SMT_CLKSEL_LO       1
`define SMT_SPLIT_BIT       0
`define SMT_CMD_HI          3
`define SMT_CMD_LO          2
`define SMT_TGT_HI          1
`define SMT_TGT_LO          0
`define SMT_RUN_HALT_BIT    0
`define SMT_LOW_UNDERFLOW_BIT        0
`define SMT_HIGH_UNDERFLOW_BIT        1
`define SMT_LCMP_LO         4
`define SMT_INT_MASK        8'h73

// ==========================================================================
// Values
`define SMT_TGT_NONE        2'h0
`define SMT_TGT_BOTH        2'h3
`define SMT_TOP_RST         8'hff
`define SMT_ZERO8           8'h00
`define SMT_ALIGN_OK        2'h0

// ==========================================================================
// Prescaler tap masks for divide by 1, 2, 4, 8, 16, 64, 256, 1024
`define SMT_PSC_DIV1        10'h000
`define SMT_PSC_DIV2        10'h001
`define SMT_PSC_DIV4        10'h003
`define SMT_PSC_DIV8        10'h007
`define SMT_PSC_DIV16       10'h00f
`define SMT_PSC_DIV64       10'h03f
`define SMT_PSC_DIV256      10'h0ff
`define SMT_PSC_DIV1024     10'h3ff
`define SMT_PSC_ONE         10'h001

`endif

// File: verilog/smt_top.sv
// Split-mode dual 8-bit timer: APB register file, command logic, flags and compares.
// Assumes an APB3 master on clk; debug_halt comes from the core on the same clock.
//
// Notes on behaviour
// - Clear-alias write clears target bits written one, others kept.
// - Set-alias write sets target bits written one; both aliases share storage.
// - Command field always reads back as zero.
// - Command 0 nothing, 2 restarts, 3 hard-resets only while disabled.
// - Command field gives software restart and reset control.
// - Target field: 0 selects none, 3 selects both byte timers.
// - Low compare enable bits 6:4 pass compare flags to interrupt.
// - Enable bit 1 passes high underflow flag to interrupt.
// - Enable bit 0 passes low underflow flag to interrupt.
// - Low compare flag n set on a tick while low count equals compare n.
// - Flags clear only on writing one or on hard reset; zero leaves them.
// - High underflow flag set at high BOTTOM, cleared by writing bit 1.
// - Low underflow flag set at low BOTTOM, cleared by writing bit 0.
// - Run-while-halted zero: stop counting during debug halt.
// - Run-while-halted one: keep counting during debug halt.
// - Software counter write beats count, clear or reload that cycle.
// - Low top register holds low TOP, resets to all ones.
// - Split bit set makes two independent 8-bit timers.
// - High top register holds high TOP value.
// - Low compare registers compared continuously with low count.
// - High compare registers compared continuously with high count.
`timescale 1ns/1ps
`include "smt_regs.svh"

module smt_top (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        debug_halt,
    output logic             irq,
    output logic [2:0]       low_match,
    output logic [2:0]       high_match
);

    // ======================================================================
    // State and wires
    smt_pkg::smt_regs_t r_reg;
    smt_pkg::smt_regs_t r_next;

    // Counter values and timer events
    logic [7:0] low_count;
    logic [7:0] high_count;
    logic       low_unf;
    logic       high_unf;
    logic       tick;
    logic       active;

    // Bus and command decode
    logic       setup;
    logic       wr_ok;
    logic [5:0] idx;
    logic [7:0] wb;
    logic       cmd_fire;
    logic       do_restart;
    logic       do_hard;
    logic       low_wr;
    logic       high_wr;
    smt_pkg::smt_cmd_t cmd;

    // ======================================================================
    // Decode helpers
    function automatic logic is_cmp(input logic [5:0] i);
        is_cmp = (i >= `SMT_IDX_CMP_FIRST) && (i <= `SMT_IDX_CMP_LAST);
    endfunction

    // Compare registers interleave low and high: offset bit 0 picks high
    function automatic logic [2:0] cmp_off(input logic [5:0] i);
        logic [5:0] d;
        d = i - `SMT_IDX_CMP_FIRST;
        cmp_off = d[2:0];
    endfunction

    function automatic logic is_mapped(input logic [5:0] i);
        case (i)
            `SMT_IDX_CTRL_A,
            `SMT_IDX_SPLIT,
            `SMT_IDX_CMD_CLR,
            `SMT_IDX_CMD_SET,
            `SMT_IDX_INT_EN,
            `SMT_IDX_INT_FLAG,
            `SMT_IDX_DEBUG,
            `SMT_IDX_LOW_COUNT,
            `SMT_IDX_HIGH_COUNT,
            `SMT_IDX_LOW_TOP,
            `SMT_IDX_HIGH_TOP: begin
                is_mapped = 1'b1;
            end
            default: begin
                is_mapped = is_cmp(i);
            end
        endcase
    endfunction

    function automatic logic [7:0] rd_byte(input logic [5:0] i,
                                           input smt_pkg::smt_regs_t s,
                                           input logic [7:0] lc,
                                           input logic [7:0] hc);
        logic [7:0] v;
        logic [2:0] o;
        v = `SMT_ZERO8;
        o = cmp_off(i);
        case (i)
            `SMT_IDX_CTRL_A: begin
                v[`SMT_CLKSEL_HI:`SMT_CLKSEL_LO] = s.clksel;
                v[`SMT_EN_BIT] = s.enable;
            end

            `SMT_IDX_SPLIT: begin
                v[`SMT_SPLIT_BIT] = s.split;
            end

            `SMT_IDX_CMD_CLR, `SMT_IDX_CMD_SET: begin
                v[`SMT_TGT_HI:`SMT_TGT_LO] = s.target;
            end

            `SMT_IDX_INT_EN: begin
                v = s.inten;
            end

            `SMT_IDX_INT_FLAG: begin
                v = s.flags;
            end

            `SMT_IDX_DEBUG: begin
                v[`SMT_RUN_HALT_BIT] = s.run_halt;
            end

            `SMT_IDX_LOW_COUNT: begin
                v = lc;
            end

            `SMT_IDX_HIGH_COUNT: begin
                v = hc;
            end

            `SMT_IDX_LOW_TOP: begin
                v = s.low_top;
            end

            `SMT_IDX_HIGH_TOP: begin
                v = s.high_top;
            end

            default: begin
                if (is_cmp(i)) begin
                    if (o[0]) begin
                        v = s.high_cmp[o[2:1]];
                    end else begin
                        v = s.low_cmp[o[2:1]];
                    end
                end
            end
        endcase
        rd_byte = v;
    endfunction

    // ======================================================================
    // Bus decode and commands
    assign setup   = psel && !penable;
    assign pready  = psel && penable;
    assign idx     = paddr[7:2];
    assign wb      = pwdata[7:0];
    // Error was decided in the setup cycle and is held in slverr
    assign wr_ok   = psel && penable && pwrite && !r_reg.slverr;
    assign prdata  = r_reg.rdata;
    assign pslverr = r_reg.slverr;
    assign irq        = r_reg.irq;
    assign low_match  = r_reg.low_match;
    assign high_match = r_reg.high_match;

    assign cmd      = smt_pkg::smt_cmd_t'(wb[`SMT_CMD_HI:`SMT_CMD_LO]);
    // Target is taken from the same write as the command
    assign cmd_fire = wr_ok && (idx == `SMT_IDX_CMD_SET)
                      && (wb[`SMT_TGT_HI:`SMT_TGT_LO] == `SMT_TGT_BOTH);
    assign do_restart = cmd_fire && (cmd == smt_pkg::smt_cmd_restart);
    assign do_hard    = cmd_fire && (cmd == smt_pkg::smt_cmd_reset)
                        && !r_reg.enable;

    // Debug halt with run_halt zero freezes the prescaler, so no tick, match flag or underflow occurs
    assign active = r_reg.enable && r_reg.split
                    && (!debug_halt || r_reg.run_halt);

    assign low_wr  = wr_ok && (idx == `SMT_IDX_LOW_COUNT);
    assign high_wr = wr_ok && (idx == `SMT_IDX_HIGH_COUNT);

    // ======================================================================
    // Prescaler and the two byte timers
    smt_prescaler u_psc (
        .clk   (clk),
        .rst   (rst),
        .run   (active),
        .clear (do_restart || do_hard),
        .sel   (r_reg.clksel),
        .tick  (tick)
    );

    smt_byte_timer u_low (
        .clk        (clk),
        .rst        (rst),
        .tick       (tick),
        .wr_en      (low_wr),
        .wr_val     (wb),
        .restart    (do_restart),
        .hard_clear (do_hard),
        .top        (r_reg.low_top),
        .count      (low_count),
        .underflow  (low_unf)
    );

    smt_byte_timer u_high (
        .clk        (clk),
        .rst        (rst),
        .tick       (tick),
        .wr_en      (high_wr),
        .wr_val     (wb),
        .restart    (do_restart),
        .hard_clear (do_hard),
        .top        (r_reg.high_top),
        .count      (high_count),
        .underflow  (high_unf)
    );

    // ======================================================================
    // Register file, flags and compares
    always_comb begin
        logic [7:0] w1c;
        logic [7:0] ev;
        logic [2:0] o;
        w1c = `SMT_ZERO8;
        ev  = `SMT_ZERO8;
        o   = cmp_off(idx);
        r_next = r_reg;

        // Read data and error are fixed in setup and stand through the access
        if (setup) begin
            r_next.rdata  = {24'h000000, rd_byte(idx, r_reg, low_count, high_count)};
            r_next.slverr = !is_mapped(idx) || (paddr[1:0] != `SMT_ALIGN_OK);
        end

        // Register writes; the two aliases only touch the target bits
        if (wr_ok) begin
            case (idx)
                `SMT_IDX_CTRL_A: begin
                    r_next.enable = wb[`SMT_EN_BIT];
                    r_next.clksel = wb[`SMT_CLKSEL_HI:`SMT_CLKSEL_LO];
                end

                `SMT_IDX_SPLIT: begin
                    r_next.split = wb[`SMT_SPLIT_BIT];
                end

                `SMT_IDX_CMD_CLR: begin
                    r_next.target = r_reg.target & ~wb[`SMT_TGT_HI:`SMT_TGT_LO];
                end

                `SMT_IDX_CMD_SET: begin
                    r_next.target = r_reg.target | wb[`SMT_TGT_HI:`SMT_TGT_LO];
                end

                `SMT_IDX_INT_EN: begin
                    r_next.inten = wb & `SMT_INT_MASK;
                end

                `SMT_IDX_INT_FLAG: begin
                    w1c = wb & `SMT_INT_MASK;
                end

                `SMT_IDX_DEBUG: begin
                    r_next.run_halt = wb[`SMT_RUN_HALT_BIT];
                end

                `SMT_IDX_LOW_TOP: begin
                    r_next.low_top = wb;
                end

                `SMT_IDX_HIGH_TOP: begin
                    r_next.high_top = wb;
                end

                default: begin
                    if (is_cmp(idx)) begin
                        if (o[0]) begin
                            r_next.high_cmp[o[2:1]] = wb;
                        end else begin
                            r_next.low_cmp[o[2:1]] = wb;
                        end
                    end
                end
            endcase
        end

        // Events of this cycle
        for (int i = 0; i < 3; i++) begin
            ev[`SMT_LCMP_LO + i] = tick && (low_count == r_reg.low_cmp[i]);
            r_next.low_match[i]  = (low_count == r_reg.low_cmp[i]);
            r_next.high_match[i] = (high_count == r_reg.high_cmp[i]);
        end
        ev[`SMT_HIGH_UNDERFLOW_BIT] = high_unf;
        ev[`SMT_LOW_UNDERFLOW_BIT] = low_unf;

        // A new event in the clearing cycle keeps its flag
        r_next.flags = (r_reg.flags & ~w1c) | ev;

        // Hard reset returns tops, compares, flags and target to their reset values
        if (do_hard) begin
            r_next.low_top  = `SMT_TOP_RST;
            r_next.high_top = `SMT_TOP_RST;
            r_next.low_cmp  = '0;
            r_next.high_cmp = '0;
            r_next.flags    = `SMT_ZERO8;
            r_next.target   = `SMT_TGT_NONE;
        end

        r_next.irq = |(r_next.flags & r_next.inten);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r_reg          <= '0;
            r_reg.low_top  <= `SMT_TOP_RST;
            r_reg.high_top <= `SMT_TOP_RST;
        end else begin
            r_reg <= r_next;
        end
    end

endmodule // smt_top
